// ### design/tcm_regs.svh
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH
`define TCM_MODE_CFG_OFFSET 12'h01c
`define TCM_CH_ENABLE_OFFSET 12'h020
`define TCM_MODE_CFG_RESET 16'h0000
`define TCM_CH_ENABLE_RESET 32'h00000000
`define TCM_CH3_SEL_LSB 0
`define TCM_CH3_FAST_BIT 2
`define TCM_CH3_PRELOAD_BIT 3
`define TCM_CH3_MODE_LSB 4
`define TCM_CH3_CLEAR_BIT 7
`define TCM_CH4_SEL_LSB 8
`define TCM_CH4_FAST_BIT 10
`define TCM_CH4_PRELOAD_BIT 11
`define TCM_CH4_MODE_LSB 12
`define TCM_CH4_CLEAR_BIT 15
`define TCM_CH3_EN_BIT 8
`define TCM_CH4_EN_BIT 12
`define TCM_TRIGGER_SOURCE_SELECT_LSB 16
`define TCM_PWM1_MODE 3'h6
`define TCM_PWM2_MODE 3'h7
`endif

// ### design/tcm_pkg.sv
package tcm_pkg;
    typedef enum logic [1:0] {
        TCM_DIR_OUTPUT = 2'b00,
        TCM_DIR_IN_DIRECT = 2'b01,
        TCM_DIR_IN_CROSS = 2'b10,
        TCM_DIR_IN_TRIG = 2'b11
    } tcm_dir_t;
endpackage : tcm_pkg

// ### design/tcm_chan_if.sv
`timescale 1ns/1ps
interface tcm_chan_if;
    logic [3:0] filter;
    logic [1:0] prescaler;
    logic enable;
    logic in_raw;
    logic capture;
    modport ctrl (output filter, output prescaler, output enable, output in_raw, input capture);
    modport chan (input filter, input prescaler, input enable, input in_raw, output capture);
endinterface : tcm_chan_if

// ### design/tcm_capture_chan.sv
`timescale 1ns/1ps
module tcm_capture_chan
    import tcm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    tcm_chan_if.chan ch
);
    logic [5:0] div_cnt, next_div_cnt;
    logic [3:0] run_cnt, next_run_cnt;
    logic filt, next_filt;
    logic filt_d, next_filt_d;
    logic [2:0] psc_cnt, next_psc_cnt;
    logic cap, next_cap;
    logic [5:0] div_max;
    logic [3:0] need_n;
    logic tick;
    logic [2:0] psc_max;

    // Filter code to sampling divider and run length, one cycle per sample at 1x.
    always_comb begin
        div_max = 6'h00;
        need_n = 4'h1;
        case (ch.filter)
            4'h0: begin div_max = 6'h00; need_n = 4'h1; end
            4'h1: begin div_max = 6'h00; need_n = 4'h2; end
            4'h2: begin div_max = 6'h00; need_n = 4'h4; end
            4'h3: begin div_max = 6'h00; need_n = 4'h8; end
            4'h4: begin div_max = 6'h01; need_n = 4'h6; end
            4'h5: begin div_max = 6'h01; need_n = 4'h8; end
            4'h6: begin div_max = 6'h03; need_n = 4'h6; end
            4'h7: begin div_max = 6'h03; need_n = 4'h8; end
            4'h8: begin div_max = 6'h07; need_n = 4'h6; end
            4'h9: begin div_max = 6'h07; need_n = 4'h8; end
            4'ha: begin div_max = 6'h0f; need_n = 4'h5; end
            4'hb: begin div_max = 6'h0f; need_n = 4'h6; end
            4'hc: begin div_max = 6'h0f; need_n = 4'h8; end
            4'hd: begin div_max = 6'h1f; need_n = 4'h5; end
            4'he: begin div_max = 6'h1f; need_n = 4'h6; end
            default: begin div_max = 6'h1f; need_n = 4'h8; end
        endcase
        case (ch.prescaler)
            2'h0: psc_max = 3'h0;
            2'h1: psc_max = 3'h1;
            2'h2: psc_max = 3'h3;
            default: psc_max = 3'h7;
        endcase
    end

    always_comb begin
        tick = (div_cnt >= div_max);
        next_div_cnt = tick ? 6'h00 : div_cnt + 6'h01;
        next_run_cnt = run_cnt;
        next_filt = filt;
        if (tick) begin
            if (ch.in_raw == filt) begin
                next_run_cnt = 4'h0;
            end else if (run_cnt + 4'h1 >= need_n) begin
                next_filt = ch.in_raw;
                next_run_cnt = 4'h0;
            end else begin
                next_run_cnt = run_cnt + 4'h1;
            end
        end
        next_filt_d = filt;
        next_cap = 1'b0;
        next_psc_cnt = psc_cnt;
        if (!ch.enable) begin
            next_psc_cnt = 3'h0;
        end else if (filt && !filt_d) begin
            if (psc_cnt >= psc_max) begin
                next_psc_cnt = 3'h0;
                next_cap = 1'b1;
            end else begin
                next_psc_cnt = psc_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 6'h00;
            run_cnt <= 4'h0;
            filt <= 1'b0;
            filt_d <= 1'b0;
            psc_cnt <= 3'h0;
            cap <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            run_cnt <= next_run_cnt;
            filt <= next_filt;
            filt_d <= next_filt_d;
            psc_cnt <= next_psc_cnt;
            cap <= next_cap;
        end
    end

    assign ch.capture = cap;
endmodule : tcm_capture_chan

// ### design/tcm_sync2.sv
`timescale 1ns/1ps
module tcm_sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta, next_meta, next_q;
    always_comb begin
        next_meta = d;
        next_q = meta;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : tcm_sync2

// ### design/tcm_ch34_mode_config.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "tcm_regs.svh"
// Contract
// - Output mode: ch4 clear enable bit 15, ch4 compare mode bits 14:12.
// - Output mode: ch4 preload enable bit 11, ch4 fast enable bit 10.
// - Output mode: ch3 clear enable bit 7, ch3 compare mode bits 6:4.
// - Output mode: ch3 preload enable bit 3, ch3 fast enable bit 2.
// - Ch4 direction bits 9:8 equal 00 make channel four an output.
// - Ch4 direction 01 uses input four, 10 uses input three.
// - Ch4 direction 11 uses internal trigger, only when trigger select is internal.
// - Ch4 direction writes accepted only while ch4 enable is 0.
// - Ch3 direction bits 1:0 equal 00 make channel three an output.
// - Ch3 direction 01 uses input three, 10 uses input four.
// - Ch3 direction 11 uses internal trigger, only when trigger select is internal.
// - Ch3 direction writes accepted only while ch3 enable is 0.
// - Input mode: ch4 capture filter bits 15:12, prescaler bits 11:10.
// - Input mode: ch3 capture filter bits 7:4, prescaler bits 3:2.
// - Prescaler 00/01/10/11 captures every 1, 2, 4 or 8 edges.
// - Prescaler counter is cleared while the channel enable is 0.
// - Fast enable acts only in the two PWM compare modes.
module tcm_ch34_mode_config
    import tcm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TIMER_INPUT_THREE,
    input wire logic TIMER_INPUT_FOUR,
    input wire logic INTERNAL_TRIGGER_SIGNAL,
    output logic [2:0] CH3_COMPARE_MODE,
    output logic CH3_CLEAR_ENABLE,
    output logic CH3_PRELOAD_ENABLE,
    output logic CH3_FAST_ENABLE,
    output logic CH3_IS_OUTPUT,
    output logic CH3_CAPTURE,
    output logic [2:0] CH4_COMPARE_MODE,
    output logic CH4_CLEAR_ENABLE,
    output logic CH4_PRELOAD_ENABLE,
    output logic CH4_FAST_ENABLE,
    output logic CH4_IS_OUTPUT,
    output logic CH4_CAPTURE
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] mode_cfg, next_mode_cfg;
    logic ch3_enable, next_ch3_enable;
    logic ch4_enable, next_ch4_enable;
    logic [2:0] trigger_source_select, next_trigger_source_select;
    logic [31:0] rdata, next_rdata;
    logic err, next_err;
    logic wr_acc, rd_acc, hit_cfg, hit_en, setup_ph;
    logic [2:0] pins_sync;
    tcm_dir_t ch3_dir, ch4_dir;
    logic trig_internal;

    // Pins are asynchronous to the kernel clock and pass two flops first.
    tcm_sync2 #(.WIDTH(3)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .d({INTERNAL_TRIGGER_SIGNAL, TIMER_INPUT_FOUR, TIMER_INPUT_THREE}),
        .q(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait state, registered read data.
    assign PREADY = 1'b1;
    assign PSLVERR = err;
    assign PRDATA = rdata;
    assign hit_cfg = (PADDR == `TCM_MODE_CFG_OFFSET);
    assign hit_en = (PADDR == `TCM_CH_ENABLE_OFFSET);
    assign setup_ph = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign rd_acc = setup_ph && !PWRITE;

    // Writes land at the access edge, where the master samples pready high.
    // Reads are looked up at the setup edge so that registered data and the
    // error flag already stand in the access cycle; a read has no side effect.
    always_comb begin
        next_mode_cfg = mode_cfg;
        next_ch3_enable = ch3_enable;
        next_ch4_enable = ch4_enable;
        next_trigger_source_select = trigger_source_select;
        next_rdata = rdata;
        next_err = setup_ph && !hit_cfg && !hit_en;
        if (wr_acc) begin
            if (hit_cfg) begin
                next_mode_cfg[15:10] = PWDATA[15:10];
                next_mode_cfg[7:2] = PWDATA[7:2];
                if (!ch4_enable) begin
                    next_mode_cfg[9:8] = PWDATA[9:8];
                end
                if (!ch3_enable) begin
                    next_mode_cfg[1:0] = PWDATA[1:0];
                end
            end else if (hit_en) begin
                next_ch3_enable = PWDATA[`TCM_CH3_EN_BIT];
                next_ch4_enable = PWDATA[`TCM_CH4_EN_BIT];
                next_trigger_source_select = PWDATA[`TCM_TRIGGER_SOURCE_SELECT_LSB +: 3];
            end
        end
        if (rd_acc) begin
            if (hit_cfg) begin
                next_rdata = {16'h0000, mode_cfg};
            end else if (hit_en) begin
                next_rdata = 32'h00000000;
                next_rdata[`TCM_CH3_EN_BIT] = ch3_enable;
                next_rdata[`TCM_CH4_EN_BIT] = ch4_enable;
                next_rdata[`TCM_TRIGGER_SOURCE_SELECT_LSB +: 3] = trigger_source_select;
            end else begin
                next_rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            mode_cfg <= `TCM_MODE_CFG_RESET;
            ch3_enable <= 1'b0;
            ch4_enable <= 1'b0;
            trigger_source_select <= 3'h0;
            rdata <= `TCM_CH_ENABLE_RESET;
            err <= 1'b0;
        end else begin
            mode_cfg <= next_mode_cfg;
            ch3_enable <= next_ch3_enable;
            ch4_enable <= next_ch4_enable;
            trigger_source_select <= next_trigger_source_select;
            rdata <= next_rdata;
            err <= next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode. Input fields reuse the same stored bits.
    assign ch3_dir = tcm_dir_t'(mode_cfg[`TCM_CH3_SEL_LSB +: 2]);
    assign ch4_dir = tcm_dir_t'(mode_cfg[`TCM_CH4_SEL_LSB +: 2]);
    // Codes 0 to 3 of the trigger select pick the internal trigger sources.
    assign trig_internal = trigger_source_select[2] == 1'b0;

    tcm_chan_if ch3_if ();
    tcm_chan_if ch4_if ();

    always_comb begin
        CH3_IS_OUTPUT = (ch3_dir == TCM_DIR_OUTPUT);
        CH4_IS_OUTPUT = (ch4_dir == TCM_DIR_OUTPUT);
        CH3_COMPARE_MODE = CH3_IS_OUTPUT ? mode_cfg[`TCM_CH3_MODE_LSB +: 3] : 3'h0;
        CH3_CLEAR_ENABLE = CH3_IS_OUTPUT && mode_cfg[`TCM_CH3_CLEAR_BIT];
        CH3_PRELOAD_ENABLE = CH3_IS_OUTPUT && mode_cfg[`TCM_CH3_PRELOAD_BIT];
        CH3_FAST_ENABLE = CH3_IS_OUTPUT && mode_cfg[`TCM_CH3_FAST_BIT]
            && (CH3_COMPARE_MODE == `TCM_PWM1_MODE || CH3_COMPARE_MODE == `TCM_PWM2_MODE);
        CH4_COMPARE_MODE = CH4_IS_OUTPUT ? mode_cfg[`TCM_CH4_MODE_LSB +: 3] : 3'h0;
        CH4_CLEAR_ENABLE = CH4_IS_OUTPUT && mode_cfg[`TCM_CH4_CLEAR_BIT];
        CH4_PRELOAD_ENABLE = CH4_IS_OUTPUT && mode_cfg[`TCM_CH4_PRELOAD_BIT];
        CH4_FAST_ENABLE = CH4_IS_OUTPUT && mode_cfg[`TCM_CH4_FAST_BIT]
            && (CH4_COMPARE_MODE == `TCM_PWM1_MODE || CH4_COMPARE_MODE == `TCM_PWM2_MODE);
        ch3_if.filter = mode_cfg[7:4];
        ch3_if.prescaler = mode_cfg[3:2];
        ch4_if.filter = mode_cfg[15:12];
        ch4_if.prescaler = mode_cfg[11:10];
        ch3_if.enable = ch3_enable && !CH3_IS_OUTPUT;
        ch4_if.enable = ch4_enable && !CH4_IS_OUTPUT;
        case (ch3_dir)
            TCM_DIR_IN_DIRECT: ch3_if.in_raw = pins_sync[0];
            TCM_DIR_IN_CROSS: ch3_if.in_raw = pins_sync[1];
            TCM_DIR_IN_TRIG: ch3_if.in_raw = trig_internal && pins_sync[2];
            default: ch3_if.in_raw = 1'b0;
        endcase
        case (ch4_dir)
            TCM_DIR_IN_DIRECT: ch4_if.in_raw = pins_sync[1];
            TCM_DIR_IN_CROSS: ch4_if.in_raw = pins_sync[0];
            TCM_DIR_IN_TRIG: ch4_if.in_raw = trig_internal && pins_sync[2];
            default: ch4_if.in_raw = 1'b0;
        endcase
    end

    tcm_capture_chan u_ch3 (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ch(ch3_if)
    );
    tcm_capture_chan u_ch4 (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ch(ch4_if)
    );

    assign CH3_CAPTURE = ch3_if.capture;
    assign CH4_CAPTURE = ch4_if.capture;
endmodule : tcm_ch34_mode_config

// ### tb/tcm_ch34_monitor.sv
`timescale 1ns/1ps
module tcm_ch34_monitor (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PSLVERR,
    input wire logic [2:0] CH3_COMPARE_MODE,
    input wire logic CH3_CLEAR_ENABLE,
    input wire logic CH3_FAST_ENABLE,
    input wire logic CH3_IS_OUTPUT,
    input wire logic [2:0] CH4_COMPARE_MODE,
    input wire logic CH4_FAST_ENABLE,
    input wire logic CH4_IS_OUTPUT
);
    logic en3;
    logic en4;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Channel enables are mirrored from bus writes, since the checker sees only ports.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            en3 <= 1'b0;
            en4 <= 1'b0;
        end else if (PSEL && PENABLE && PWRITE && PADDR == 12'h020) begin
            en3 <= PWDATA[8];
            en4 <= PWDATA[12];
        end
    end
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    // A write takes effect at the access edge, so its result is seen one edge later.
    sequence cfg_wr_s;
        access_s ##0 (PWRITE && PADDR == 12'h01c);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    fast_ch3_a: assert property (CH3_FAST_ENABLE |-> CH3_COMPARE_MODE[2:1] == 2'b11)
        else $error("Ch3 fast enable outside pwm modes.");
    fast_ch4_a: assert property (CH4_FAST_ENABLE |-> CH4_COMPARE_MODE[2:1] == 2'b11)
        else $error("Ch4 fast enable outside pwm modes.");
    input_quiet_a: assert property (!CH3_IS_OUTPUT |-> {CH3_CLEAR_ENABLE, CH3_COMPARE_MODE} == 4'h0)
        else $error("Ch3 compare controls active in input mode.");
    dir_hold3_a: assert property (cfg_wr_s ##0 en3 |=> $stable(CH3_IS_OUTPUT))
        else $error("Ch3 direction changed while enabled.");
    dir_hold4_a: assert property (cfg_wr_s ##0 en4 |=> $stable(CH4_IS_OUTPUT))
        else $error("Ch4 direction changed while enabled.");
    dir_out3_a: assert property (cfg_wr_s ##0 (!en3 && PWDATA[1:0] == 2'b00) |=> CH3_IS_OUTPUT)
        else $error("Ch3 not output after direction 00.");
    dir_out4_a: assert property (cfg_wr_s ##0 (!en4 && PWDATA[9:8] == 2'b00) |=> CH4_IS_OUTPUT)
        else $error("Ch4 not output after direction 00.");
    bus_error_a: assert property (setup_s
        |=> PSLVERR == ($past(PADDR) != 12'h01c && $past(PADDR) != 12'h020))
        else $error("Slave error does not match address decode.");
endmodule : tcm_ch34_monitor
bind tcm_ch34_mode_config tcm_ch34_monitor tcm_ch34_monitor_inst (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSLVERR(PSLVERR), .CH3_COMPARE_MODE(CH3_COMPARE_MODE),
    .CH3_CLEAR_ENABLE(CH3_CLEAR_ENABLE), .CH3_FAST_ENABLE(CH3_FAST_ENABLE),
    .CH3_IS_OUTPUT(CH3_IS_OUTPUT), .CH4_COMPARE_MODE(CH4_COMPARE_MODE),
    .CH4_FAST_ENABLE(CH4_FAST_ENABLE), .CH4_IS_OUTPUT(CH4_IS_OUTPUT));

// ### tb/tcm_ch34_mode_config_tb_top.sv
`timescale 1ns/1ps
module tcm_ch34_mode_config_tb_top;
    logic CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, en_mdl;
    logic [2:0] tin, CH3_COMPARE_MODE, CH4_COMPARE_MODE;
    logic CH3_CLEAR_ENABLE, CH3_PRELOAD_ENABLE, CH3_FAST_ENABLE, CH3_IS_OUTPUT, CH3_CAPTURE;
    logic CH4_CLEAR_ENABLE, CH4_PRELOAD_ENABLE, CH4_FAST_ENABLE, CH4_IS_OUTPUT, CH4_CAPTURE;
    logic [15:0] mdl;
    int n_fail = 0, tests_run = 0, c3 = 0, c4 = 0;
    tcm_ch34_mode_config tcm_ch34_mode_config_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_INPUT_THREE(tin[0]),
        .TIMER_INPUT_FOUR(tin[1]), .INTERNAL_TRIGGER_SIGNAL(tin[2]),
        .CH3_COMPARE_MODE(CH3_COMPARE_MODE), .CH3_CLEAR_ENABLE(CH3_CLEAR_ENABLE),
        .CH3_PRELOAD_ENABLE(CH3_PRELOAD_ENABLE), .CH3_FAST_ENABLE(CH3_FAST_ENABLE),
        .CH3_IS_OUTPUT(CH3_IS_OUTPUT), .CH3_CAPTURE(CH3_CAPTURE),
        .CH4_COMPARE_MODE(CH4_COMPARE_MODE), .CH4_CLEAR_ENABLE(CH4_CLEAR_ENABLE),
        .CH4_PRELOAD_ENABLE(CH4_PRELOAD_ENABLE), .CH4_FAST_ENABLE(CH4_FAST_ENABLE),
        .CH4_IS_OUTPUT(CH4_IS_OUTPUT), .CH4_CAPTURE(CH4_CAPTURE));
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        if (CH3_CAPTURE === 1'b1) c3++;
        if (CH4_CAPTURE === 1'b1) c4++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            stop_test();
        end else begin
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge CLK_SYS);
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == 12'h020) en_mdl = d;
        if (a == 12'h01c) mdl = {d[15:10], en_mdl[12] ? mdl[9:8] : d[9:8], d[7:2],
            en_mdl[8] ? mdl[1:0] : d[1:0]};
    endtask : wr
    function automatic logic [6:0] exp_ch(input logic [7:0] f);
        return (f[1:0] == 2'b00) ? {f[7:3], f[2] & (f[6:5] == 2'b11), 1'b1} : 7'h00;
    endfunction : exp_ch
    task automatic chk_regs();
        apb(1'b0, 12'h01c, 32'h0);
        chk("cfg", rd, {16'h0, mdl});
        chk("cfg_err", {31'h0, er}, 32'h0);
        chk("ch3", {25'h0, CH3_CLEAR_ENABLE, CH3_COMPARE_MODE, CH3_PRELOAD_ENABLE,
            CH3_FAST_ENABLE, CH3_IS_OUTPUT}, {25'h0, exp_ch(mdl[7:0])});
        chk("ch4", {25'h0, CH4_CLEAR_ENABLE, CH4_COMPARE_MODE, CH4_PRELOAD_ENABLE,
            CH4_FAST_ENABLE, CH4_IS_OUTPUT}, {25'h0, exp_ch(mdl[15:8])});
    endtask : chk_regs
    // Low time of twelve cycles leaves room for the longest fast filter to settle.
    task automatic pulses(input int s, input int n, input int w);
        repeat (n) begin
            tin[s] <= 1'b1;
            repeat (w) @(posedge CLK_SYS);
            tin[s] <= 1'b0;
            repeat (12) @(posedge CLK_SYS);
        end
        repeat (60) @(posedge CLK_SYS);
    endtask : pulses
    task automatic map_case(input int d, input int s, input logic [31:0] en, input int e3,
        input int e4);
        wr(12'h020, 32'h0);
        wr(12'h01c, {16'h0, 6'h0, d[1:0], 6'h0, d[1:0]});
        wr(12'h020, en);
        c3 = 0;
        c4 = 0;
        pulses(s, 3, 12);
        chk("map3", c3, e3);
        chk("map4", c4, e4);
    endtask : map_case
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
    initial begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h0;
        PWDATA = 32'h0;
        tin = 3'h0;
        mdl = 16'h0;
        en_mdl = 32'h0;
        void'($urandom(15649));
        repeat (4) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        chk_regs();
        $display("Test reset done");
        for (int i = 0; i < 32; i++) begin
            wr(12'h01c, i < 8 ? {16'h0, {2{1'b1, i[2:0], 4'hc}}} : $urandom);
            chk_regs();
        end
        $display("Test output fields done");
        for (int j = 1; j < 4; j++) begin
            wr(12'h020, {19'h0, j[1], 3'h0, j[0], 8'h0});
            repeat (4) begin
                wr(12'h01c, $urandom);
                chk_regs();
            end
        end
        $display("Test direction lock done");
        apb(1'b1, 12'h040, $urandom);
        chk("bad_wr_err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h040, 32'h0);
        chk("bad_rd_err", {31'h0, er}, 32'h1);
        chk("bad_rd", rd, 32'h0);
        chk_regs();
        $display("Test unmapped done");
        for (int p = 0; p < 4; p++) begin
            wr(12'h020, 32'h0);
            wr(12'h01c, {16'h0, 6'h0, 2'b10, p[3:0], p[1:0], 2'b01});
            wr(12'h020, 32'h1100);
            c3 = 0;
            c4 = 0;
            pulses(0, 8, 12);
            pulses(0, 4, 1);
            chk("psc3", c3, (p == 0 ? 12 : 8) >> p);
            chk("psc4", c4, 12);
        end
        wr(12'h020, 32'h0);
        wr(12'h01c, {16'h0, 8'h05, 8'h05});
        wr(12'h020, 32'h1100);
        c3 = 0;
        pulses(0, 1, 12);
        wr(12'h020, 32'h0);
        wr(12'h020, 32'h1100);
        pulses(0, 1, 12);
        chk("psc_clear", c3, 0);
        $display("Test capture done");
        for (int d = 1; d < 4; d++) begin
            for (int s = 0; s < 3; s++) begin
                map_case(d, s, 32'h1100, (d - 1 == s) ? 3 : 0, ((d == 3) ? 2 : 2 - d) == s ? 3 : 0);
            end
        end
        map_case(3, 2, 32'h41100, 0, 0);
        $display("Test input map done");
        stop_test();
    end
endmodule : tcm_ch34_mode_config_tb_top
